// ### src/snd_cmd_front.sv
// serial flash command front end: framing, busy gating, block protect, max bit-flip report
// Notes on behaviour
// - register 30h holds worst sector flip count
// - count codes 0-4 corrected, 7 uncorrected
// - low three bits give worst sector number
// - ties report the lowest sector number
// - protect code selects top/bottom power-of-two blocks
// - program or erase on protected block ignored
// - chip select fall starts, first byte opcode
// - input sampled on rising clock, MSB first
// - chip select rise ends each instruction
// - reads may stop anywhere, no side effect
// - writes ending mid-byte are ignored
// - while busy only status and ID reads
// - decoder knows the 28 basic instructions
// - bytes after opcode parsed per opcode
// - maker and part identification codes readable
// - register read repeats register contents while clocked
// - protect bits read at register address Axh
`timescale 1ns/1ps
`include "snd_consts.svh"
module snd_cmd_front
	import snd_pkg::*;
#(
	parameter logic [7:0]  MAKER_CODE = 8'h5a,  // arbitrary value
	parameter logic [15:0] PART_CODE  = 16'h3c96 // arbitrary value
) (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            ce,
	input  wire logic            sclk,
	input  wire logic            csN,
	input  wire logic            si,
	output logic                 so,
	output logic                 soOeN,
	input  wire logic            engineBusy,
	input  wire logic            eccDone,
	input  wire logic            eccOn,
	input  wire logic [3:0][2:0] sectorFlips,
	output logic                 cmdValid,
	output logic [7:0]           cmdOpcode,
	output logic [15:0]          page_address
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic isKnownOp(input logic [7:0] op);
		unique case (op)
			`SND_OP_DEV_RESET, `SND_OP_READ_ID, `SND_OP_RD_REG, `SND_OP_RD_REG_ALT,
			`SND_OP_WR_REG, `SND_OP_WR_REG_ALT, `SND_OP_SWAP_BLK, `SND_OP_RD_SWAP_LUT,
			`SND_OP_RD_FAIL_PA, `SND_OP_WR_ENABLE, `SND_OP_WR_DISABLE, `SND_OP_BLK_ERASE,
			`SND_OP_LOAD, `SND_OP_LOAD_RAND, `SND_OP_LOAD_QUAD, `SND_OP_LOAD_RQUAD,
			`SND_OP_PROG_EXEC, `SND_OP_PAGE_READ, `SND_OP_READ, `SND_OP_FAST_READ,
			`SND_OP_FREAD_DO, `SND_OP_FREAD_QO, `SND_OP_FREAD_DIO, `SND_OP_FREAD_QIO,
			`SND_OP_POWER_DOWN, `SND_OP_POWER_UP, `SND_OP_RST_ENABLE,
			`SND_OP_RST_DEVICE: isKnownOp = 1'b1;
			default: isKnownOp = 1'b0;
		endcase
	endfunction
	function automatic logic isArrayRead(input logic [7:0] op);
		isArrayRead = (op == `SND_OP_READ) || (op == `SND_OP_FAST_READ) || (op == `SND_OP_FREAD_DO) ||
			(op == `SND_OP_FREAD_QO) || (op == `SND_OP_FREAD_DIO) || (op == `SND_OP_FREAD_QIO) ||
			(op == `SND_OP_RD_SWAP_LUT) || (op == `SND_OP_RD_FAIL_PA);
	endfunction
	function automatic logic isStatusRead(input logic [7:0] op);
		isStatusRead = (op == `SND_OP_RD_REG) || (op == `SND_OP_RD_REG_ALT) || (op == `SND_OP_READ_ID);
	endfunction
	function automatic logic isProtected(input logic [9:0] blk, input snd_prot_s p);
		logic [9:0] low;
		low = 10'((11'h1 << p.protectLevel) - 11'h1);
		if (p.protectLevel == 4'h0) begin
			isProtected = 1'b0;
		end else if (p.protectLevel >= `SND_LVL_ALL) begin
			isProtected = 1'b1;
		end else if (p.protect_top_bottom_select) begin
			isProtected = (blk & ~low) == 10'h000;
		end else begin
			isProtected = (blk | low) == `SND_BLOCK_LAST;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// link side: framing on the serial clock; chip select high clears the frame counters

	logic [2:0] bitPos;
	logic [2:0] byteIdx;
	logic [7:0] shiftIn;
	logic [2:0] next_bitPos;
	logic [2:0] next_byteIdx;
	logic [7:0] next_shiftIn;
	snd_frame_s frame;
	snd_frame_s next_frame;
	logic       busyS1;
	logic       busyS2;
	snd_prot_s  prot;
	snd_ecc_s   ecc;
	logic       statusBusy;

	always_comb begin
		next_bitPos  = bitPos + 3'h1;
		next_byteIdx = byteIdx;
		if (bitPos == `SND_BYTE_LAST_BIT && byteIdx != `SND_BYTE_IDX_MAX) begin
			next_byteIdx = byteIdx + 3'h1;
		end
		next_shiftIn = {shiftIn[6:0], si};
		next_frame           = frame;
		next_frame.aligned   = (next_bitPos == 3'h0);
		next_frame.byteCount = next_byteIdx;
		if (bitPos == `SND_BYTE_LAST_BIT) begin
			unique case (byteIdx)
				3'h0: next_frame.opcode = next_shiftIn;
				3'h1: next_frame.byte2  = next_shiftIn;
				3'h2: next_frame.byte3  = next_shiftIn;
				3'h3: next_frame.byte4  = next_shiftIn;
				default: next_frame.opcode = frame.opcode;
			endcase
		end
	end
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			bitPos  <= 3'h0;
			byteIdx <= 3'h0;
			shiftIn <= 8'h00;
		end else begin
			bitPos  <= next_bitPos;
			byteIdx <= next_byteIdx;
			shiftIn <= next_shiftIn;
		end
	end

	// held frame is not cleared by chip select so the core can read it after the frame
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			frame  <= '0;
			busyS1 <= 1'b0;
			busyS2 <= 1'b0;
		end else begin
			frame  <= next_frame;
			busyS1 <= statusBusy;
			busyS2 <= busyS1;
		end
	end

	// output byte; protect changes only at frame end, the report on an eccDone with eccOn while ce is high
	logic [7:0] outByte;
	logic [7:0] outShift;
	logic [7:0] next_outShift;
	logic       next_soOeN;
	always_comb begin
		outByte = 8'h00;
		if (frame.opcode == `SND_OP_READ_ID) begin
			unique case (byteIdx)
				3'h2: outByte = MAKER_CODE;
				3'h3: outByte = PART_CODE[15:8];
				3'h4: outByte = PART_CODE[7:0];
				default: outByte = 8'h00;
			endcase
		end else if (frame.byte2 == `SND_REG_ECC_MAX) begin
			outByte[`SND_ECC_CNT_LSB+:3] = ecc.max_flip_count;
			outByte[`SND_ECC_SEC_LSB+:3] = ecc.max_flip_sector;
		end else if (frame.byte2[7:4] == `SND_REG_PROT_NIB) begin
			outByte[`SND_PROT_LVL_LSB+:4] = prot.protectLevel;
			outByte[`SND_PROT_TB_BIT]     = prot.protect_top_bottom_select;
		end else if (frame.byte2[7:4] == `SND_REG_STAT_NIB) begin
			outByte[`SND_STAT_BUSY_BIT] = busyS2;
		end
		next_outShift = {outShift[6:0], 1'b0};
		next_soOeN    = soOeN;
		if (isStatusRead(frame.opcode) && byteIdx >= `SND_OUT_FIRST_BYTE && bitPos == 3'h0) begin
			next_outShift = outByte;
			next_soOeN    = 1'b0;
		end
	end

	always_ff @(negedge sclk or posedge csN) begin
		if (csN) begin
			outShift <= 8'h00;
			soOeN    <= 1'b1;
		end else begin
			outShift <= next_outShift;
			soOeN    <= next_soOeN;
		end
	end

	assign so = outShift[7];
	AST_OUT_PHASE: assert property (@(negedge sclk) disable iff (rst || csN)
		!soOeN |-> (byteIdx >= `SND_OUT_FIRST_BYTE && isStatusRead(frame.opcode)))
		else $error("output driven outside the read data phase");
	AST_MSB_FIRST: assert property (@(posedge sclk) disable iff (rst || csN)
		(byteIdx == 3'h0 && bitPos == `SND_BYTE_LAST_BIT) |=> frame.opcode[7] == $past(shiftIn[6]))
		else $error("opcode not assembled most significant bit first");
	COV_READ_OUT: cover property (@(negedge sclk) disable iff (rst || csN) $fell(soOeN));

	////////////////////////////////////////////////////////////////////////////
	// core side: frame end detection and decision

	logic csLevel;
	logic csPrev;
	logic csRise;
	snd_sync3 u_csSync (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.rstLevel (1'b0),
		.d        (csN),
		.q        (csLevel)
	);
	assign csRise = csLevel && !csPrev;
	snd_act_e   act;
	logic       isWrite;
	logic       protHit;
	snd_prot_s  next_prot;
	logic       next_cmdValid;
	logic [7:0] next_cmdOpcode;
	logic [15:0] next_pageAddr;

	always_comb begin
		act     = SND_ACT_NONE;
		isWrite = !isStatusRead(frame.opcode) && !isArrayRead(frame.opcode);
		protHit = isProtected({frame.byte3, frame.byte4[7:6]}, prot);
		if (!csRise || !isKnownOp(frame.opcode) || frame.byteCount == 3'h0) begin
			act = SND_ACT_NONE;
		end else if (statusBusy && !isStatusRead(frame.opcode)) begin
			act = SND_ACT_DROP;
		end else if (!isWrite) begin
			act = SND_ACT_NONE;
		end else if (!frame.aligned) begin
			act = SND_ACT_DROP;
		end else if (frame.opcode == `SND_OP_WR_REG || frame.opcode == `SND_OP_WR_REG_ALT) begin
			act = (frame.byte2[7:4] == `SND_REG_PROT_NIB && frame.byteCount >= 3'h3) ?
				SND_ACT_PROT_WR : SND_ACT_NONE;
		end else if (frame.opcode == `SND_OP_BLK_ERASE || frame.opcode == `SND_OP_PROG_EXEC) begin
			act = (frame.byteCount < 3'h4 || protHit) ? SND_ACT_DROP : SND_ACT_FORWARD;
		end else begin
			act = SND_ACT_FORWARD;
		end
		next_prot      = prot;
		next_cmdValid  = 1'b0;
		next_cmdOpcode = cmdOpcode;
		next_pageAddr  = page_address;
		unique case (act)
			SND_ACT_NONE, SND_ACT_DROP: next_cmdValid = 1'b0;
			SND_ACT_PROT_WR: begin
				next_prot.protectLevel              = frame.byte3[`SND_PROT_LVL_LSB+:4];
				next_prot.protect_top_bottom_select = frame.byte3[`SND_PROT_TB_BIT];
			end
			SND_ACT_FORWARD: begin
				next_cmdValid  = 1'b1;
				next_cmdOpcode = frame.opcode;
				next_pageAddr  = {frame.byte3, frame.byte4};
			end
		endcase
	end

	// worst sector search; strict compare keeps the lowest sector on a tie
	snd_ecc_s   next_ecc;
	logic [2:0] flipCode [4];
	logic       eccLoad;
	assign eccLoad = eccDone && eccOn;
	always_comb begin
		next_ecc = ecc;
		for (int i = 0; i < 4; i++) begin
			flipCode[i] = (sectorFlips[i] > `SND_FLIP_MAX_CORR) ? `SND_FLIP_UNCORR : sectorFlips[i];
		end
		if (eccLoad) begin
			next_ecc = `SND_ECC_RST;
			for (int i = 0; i < 4; i++) begin
				if (flipCode[i] > next_ecc.max_flip_count) begin
					next_ecc.max_flip_count  = flipCode[i];
					next_ecc.max_flip_sector = 3'(i);
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			csPrev       <= 1'b1;
			statusBusy   <= 1'b0;
			prot         <= `SND_PROT_RST;
			ecc          <= `SND_ECC_RST;
			cmdValid     <= 1'b0;
			cmdOpcode    <= 8'h00;
			page_address <= 16'h0000;
		end else if (ce) begin
			csPrev       <= csLevel;
			statusBusy   <= engineBusy;
			prot         <= next_prot;
			ecc          <= next_ecc;
			cmdValid     <= next_cmdValid;
			cmdOpcode    <= next_cmdOpcode;
			page_address <= next_pageAddr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	// each sector is sampled at its own fixed index; a $past of a computed index would use the old sector
	AST_ECC_SELECT: assert property (@(posedge clk) disable iff (rst)
		(ce && eccLoad) |=> ecc.max_flip_sector <= 3'h3 && ecc.max_flip_count ==
			(ecc.max_flip_sector[1] ? (ecc.max_flip_sector[0] ? $past(flipCode[3]) : $past(flipCode[2])) :
			(ecc.max_flip_sector[0] ? $past(flipCode[1]) : $past(flipCode[0]))))
		else $error("reported count does not match reported sector");
	AST_ECC_TIE: assert property (@(posedge clk) disable iff (rst)
		(ce && eccLoad) |=> ((ecc.max_flip_sector < 3'h1) || $past(flipCode[0]) < ecc.max_flip_count) &&
			((ecc.max_flip_sector < 3'h2) || $past(flipCode[1]) < ecc.max_flip_count) &&
			((ecc.max_flip_sector < 3'h3) || $past(flipCode[2]) < ecc.max_flip_count))
		else $error("lower sector with equal count not reported");
	AST_ECC_CODE: assert property (@(posedge clk) disable iff (rst)
		ecc.max_flip_count <= `SND_FLIP_MAX_CORR || ecc.max_flip_count == `SND_FLIP_UNCORR)
		else $error("illegal maximum flip code");
	AST_ZERO_SECTOR: assert property (@(posedge clk) disable iff (rst)
		ecc.max_flip_count == 3'h0 |-> ecc.max_flip_sector == 3'h0)
		else $error("sector nonzero with no errors");
	AST_PROT_BLOCK: assert property (@(posedge clk) disable iff (rst)
		(cmdValid && (cmdOpcode == `SND_OP_BLK_ERASE || cmdOpcode == `SND_OP_PROG_EXEC)) |->
			!isProtected(page_address[15:6], prot))
		else $error("protected block command forwarded");
	AST_BUSY_GATE: assert property (@(posedge clk) disable iff (rst)
		$rose(cmdValid) |-> !$past(statusBusy))
		else $error("command forwarded while busy");
	AST_ALIGNED: assert property (@(posedge clk) disable iff (rst)
		$rose(cmdValid) |-> $past(frame.aligned))
		else $error("mid-byte write forwarded");
	AST_FRAME_END: assert property (@(posedge clk) disable iff (rst)
		$rose(cmdValid) |-> $past(csRise) ##1 !cmdValid)
		else $error("command not a single pulse after frame end");
	COV_ECC_TIE: cover property (@(posedge clk) disable iff (rst)
		eccLoad && flipCode[1] == flipCode[2] && flipCode[1] != 3'h0);
	COV_FORWARD: cover property (@(posedge clk) disable iff (rst) cmdValid);
	COV_PROT_DROP: cover property (@(posedge clk) disable iff (rst) act == SND_ACT_DROP && protHit);

endmodule // snd_cmd_front

// ### src/snd_consts.svh
// constants of the serial flash command front end
`ifndef SND_CONSTS_SVH
`define SND_CONSTS_SVH

// instruction codes
`define SND_OP_DEV_RESET   8'hff
`define SND_OP_READ_ID     8'h9f
`define SND_OP_RD_REG      8'h0f
`define SND_OP_RD_REG_ALT  8'h05
`define SND_OP_WR_REG      8'h1f
`define SND_OP_WR_REG_ALT  8'h01
`define SND_OP_SWAP_BLK    8'ha1
`define SND_OP_RD_SWAP_LUT 8'ha5
`define SND_OP_RD_FAIL_PA  8'ha9
`define SND_OP_WR_ENABLE   8'h06
`define SND_OP_WR_DISABLE  8'h04
`define SND_OP_BLK_ERASE   8'hd8
`define SND_OP_LOAD        8'h02
`define SND_OP_LOAD_RAND   8'h84
`define SND_OP_LOAD_QUAD   8'h32
`define SND_OP_LOAD_RQUAD  8'h34
`define SND_OP_PROG_EXEC   8'h10
`define SND_OP_PAGE_READ   8'h13
`define SND_OP_READ        8'h03
`define SND_OP_FAST_READ   8'h0b
`define SND_OP_FREAD_DO    8'h3b
`define SND_OP_FREAD_QO    8'h6b
`define SND_OP_FREAD_DIO   8'hbb
`define SND_OP_FREAD_QIO   8'heb
`define SND_OP_POWER_DOWN  8'hb9
`define SND_OP_POWER_UP    8'hab
`define SND_OP_RST_ENABLE  8'h66
`define SND_OP_RST_DEVICE  8'h99

// register address bytes (protect and status selected by upper nibble)
`define SND_REG_PROT_NIB   4'ha
`define SND_REG_STAT_NIB   4'hc
`define SND_REG_ECC_MAX    8'h30

// field positions
`define SND_ECC_CNT_LSB    4
`define SND_ECC_SEC_LSB    0
`define SND_PROT_LVL_LSB   3
`define SND_PROT_TB_BIT    2
`define SND_STAT_BUSY_BIT  0

// reset values
`define SND_PROT_RST       5'h00
`define SND_ECC_RST        6'h00

// counts and codes
`define SND_BYTE_LAST_BIT  3'h7
`define SND_BYTE_IDX_MAX   3'h7
`define SND_OUT_FIRST_BYTE 3'h2
`define SND_FLIP_MAX_CORR  3'h4
`define SND_FLIP_UNCORR    3'h7
`define SND_LVL_ALL        4'ha
`define SND_BLOCK_LAST     10'h3ff

`endif

// ### src/snd_pkg.sv
// types of the serial flash command front end
package snd_pkg;

	typedef struct packed {
		logic       protect_top_bottom_select;
		logic [3:0] protectLevel;
	} snd_prot_s;

	typedef struct packed {
		logic [2:0] max_flip_count;
		logic [2:0] max_flip_sector;
	} snd_ecc_s;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] byte2;
		logic [7:0] byte3;
		logic [7:0] byte4;
		logic [2:0] byteCount;
		logic       aligned;
	} snd_frame_s;

	typedef enum logic [1:0] {
		SND_ACT_NONE    = 2'b00,
		SND_ACT_FORWARD = 2'b01,
		SND_ACT_PROT_WR = 2'b10,
		SND_ACT_DROP    = 2'b11
	} snd_act_e;

endpackage

// ### src/snd_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module snd_sync3 (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic rstLevel,
	input  wire logic d,
	output logic      q
);
	logic s1;
	logic s2;
	logic s3;
	logic next_q;

	always_comb begin
		next_q = q;
		if (s2 == s3) begin
			next_q = s3;
		end
	end

	// reset value is fixed to idle; rstLevel is only sampled after release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			q  <= 1'b1;
		end else if (ce) begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q  <= rstLevel ? 1'b1 : next_q;
		end
	end

endmodule // snd_sync3

// ### verification/snd_host_model.sv
// serial host model that frames instructions on the link
`timescale 1ns/1ps
module snd_host_model (
	output logic      sclk,
	output logic      csN,
	output logic      si,
	input  wire logic so,
	input  wire logic soOeN
);
	initial begin
		sclk = 1'b0;
		csN  = 1'b1;
		si   = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// one frame: csN falls, tx leaves msb first, rx keeps the last eight bits seen
	// the clock stands low outside frames; si is inverted on release so a stale level never helps
	task automatic xfer(input logic [31:0] tx, input int nBits, output logic [7:0] rx, output logic oeN);
		rx  = 8'h00;
		oeN = 1'b1;
		#13 csN = 1'b0;
		for (int i = 0; i < nBits; i++) begin
			si = (i < 32) ? tx[31-i] : 1'b0;
			#40 sclk = 1'b1;
			rx  = {rx[6:0], so};
			oeN = soOeN;
			#40 sclk = 1'b0;
		end
		#20 csN = 1'b1;
		si = ~si;
		// csN must stay high at least six core cycles between frames
		#250;
	endtask
endmodule // snd_host_model

// ### verification/test_snd_cmd_front.sv
// self-checking bench for the command front end
`timescale 1ns/1ps
module test_snd_cmd_front;
	localparam logic [7:0]  MAKER = 8'h5a;   // arbitrary value
	localparam logic [15:0] PART  = 16'h3c96; // arbitrary value
	logic            clk         = 1'b0;
	logic            rst         = 1'b1;
	logic            ce          = 1'b1;
	logic            engineBusy  = 1'b0;
	logic            eccDone     = 1'b0;
	logic            eccOn       = 1'b0;
	logic [3:0][2:0] sectorFlips = '0;
	wire logic       sclk, csN, si, so, soOeN, cmdValid;
	wire logic [7:0] cmdOpcode;
	wire logic [15:0] page_address;
	int              n_mismatch  = 0;
	int              check_count = 0;
	int              nFwd        = 0;
	int              n0;
	logic [7:0]      rx, pv, op;
	logic            oe;
	logic [11:0]     flipTab [5] = '{12'h451, 12'h3c9, 12'h000, 12'h604, 12'hfff};
	logic [4:0]      pTab [9] = '{5'h01, 5'h01, 5'h11, 5'h11, 5'h09, 5'h09, 5'h1a, 5'h0d, 5'h00};
	logic [15:0]     pPage [9] = '{16'hffc0, 16'hff40, 16'h0040, 16'h0080, 16'h7fc0, 16'h8000,
	                               16'h1234, 16'h4000, 16'hffc0};

	snd_cmd_front #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dut_u (
		.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .csN(csN), .si(si), .so(so), .soOeN(soOeN),
		.engineBusy(engineBusy), .eccDone(eccDone), .eccOn(eccOn), .sectorFlips(sectorFlips),
		.cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .page_address(page_address));
	snd_host_model host_u (.sclk(sclk), .csN(csN), .si(si), .so(so), .soOeN(soOeN));

	always #12.5 clk = ~clk;
	always @(posedge clk) if (cmdValid === 1'b1) nFwd <= nFwd + 1;

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdReg(input logic [7:0] opc, input logic [7:0] adr, output logic [7:0] v);
		logic oeN;
		host_u.xfer({opc, adr, 16'h0000}, 24, v, oeN);
		check(oeN, 1'b0);
	endtask

	task automatic wrFrame(input logic [31:0] tx, input int nBits);
		logic [7:0] v;
		logic       oeN;
		host_u.xfer(tx, nBits, v, oeN);
	endtask

	task automatic loadRep(input logic [11:0] f, input logic on);
		@(posedge clk);
		sectorFlips <= f;
		eccOn <= on;
		eccDone <= 1'b1;
		@(posedge clk);
		eccDone <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// reference report: worst count, codes above four count as uncorrected, ties keep the lowest sector
	function automatic logic [7:0] expRep(input logic [11:0] f);
		logic [2:0] best, c, sec;
		best = 3'h0;
		sec  = 3'h0;
		for (int i = 0; i < 4; i++) begin
			c = (f[3*i+:3] > 3'h4) ? 3'h7 : f[3*i+:3];
			if (c > best) begin
				best = c;
				sec  = 3'(i);
			end
		end
		return {1'b0, best, 1'b0, sec};
	endfunction

	function automatic logic isProt(input logic [4:0] p, input logic [9:0] blk);
		int size;
		size = 1 << p[3:0];
		if (p[3:0] == 4'h0) return 1'b0;
		if (p[3:0] >= 4'ha) return 1'b1;
		return p[4] ? (int'(blk) < size) : (int'(blk) >= 1024 - size);
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		#1ms;
		n_mismatch++;
		test_done();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		rdReg(8'h0f, 8'ha0, rx);
		check(rx, 8'h00);
		rdReg(8'h0f, 8'h30, rx);
		check(rx, 8'h00);
		$display("test reset done");

		for (int i = 0; i < 5; i++) begin
			loadRep(flipTab[i], i != 4);
			rdReg(i[0] ? 8'h05 : 8'h0f, 8'h30, rx);
			check(rx, expRep(flipTab[i == 4 ? 3 : i]));
		end
		wrFrame({8'h1f, 8'h30, 8'hff, 8'h00}, 24);
		rdReg(8'h0f, 8'h30, rx);
		check(rx, expRep(flipTab[3]));
		// a page read that lands while the clock enable is low must not touch the report
		@(posedge clk);
		ce <= 1'b0;
		loadRep(flipTab[0], 1'b1);
		ce <= 1'b1;
		rdReg(8'h0f, 8'h30, rx);
		check(rx, expRep(flipTab[3]));
		$display("test report done");

		for (int i = 0; i < 3; i++) begin
			host_u.xfer({8'h9f, 24'h000000}, 24 + 8 * i, rx, oe);
			check(rx, 16'(({MAKER, PART} >> (16 - 8 * i)) & 24'h0000ff));
		end
		$display("test ident done");

		for (int i = 0; i < 9; i++) begin
			pv = {1'b0, pTab[i][3:0], pTab[i][4], 2'b00};
			op = i[0] ? 8'h10 : 8'hd8;
			wrFrame({i[1] ? 8'h01 : 8'h1f, 8'ha0, pv, 8'h00}, 24);
			rdReg(8'h0f, {4'ha, 4'(i)}, rx);
			check(rx, pv);
			n0 = nFwd;
			wrFrame({op, 8'h00, pPage[i]}, 32);
			check(16'(nFwd - n0), 16'(!isProt(pTab[i], pPage[i][15:6])));
			if (!isProt(pTab[i], pPage[i][15:6])) begin
				check(cmdOpcode, op);
				check(page_address, pPage[i]);
			end
		end
		$display("test protect done");

		@(posedge clk);
		engineBusy <= 1'b1;
		n0 = nFwd;
		wrFrame({8'hd8, 8'h00, 16'hff40}, 32);
		check(16'(nFwd - n0), 16'h0000);
		rdReg(8'h0f, 8'hc0, rx);
		check(rx, 8'h01);
		host_u.xfer({8'h9f, 24'h000000}, 24, rx, oe);
		check(rx, MAKER);
		@(posedge clk);
		engineBusy <= 1'b0;
		repeat (4) @(posedge clk);
		$display("test busy done");

		n0 = nFwd;
		wrFrame({8'hd8, 8'h00, 16'hff40}, 31);
		check(16'(nFwd - n0), 16'h0000);
		wrFrame({8'h0f, 8'h30, 16'h0000}, 13);
		check(16'(nFwd - n0), 16'h0000);
		rdReg(8'h0f, 8'h30, rx);
		check(rx, expRep(flipTab[3]));
		wrFrame({8'h06, 24'h000000}, 8);
		check(16'(nFwd - n0), 16'h0001);
		check(cmdOpcode, 8'h06);
		$display("test framing done");
		test_done();
	end
endmodule // test_snd_cmd_front
